// [core/tcn_consts.svh]
// tcn_consts.svh: offsets, field positions and counts of the 16-bit timer.
// assumes inclusion by bare name from the package, the bench and the property module.
`ifndef TCN_CONSTS_SVH
`define TCN_CONSTS_SVH

`define TCN_OFF_CTRL 12'h000
`define TCN_OFF_CNTL 12'h004
`define TCN_OFF_CNTH 12'h008
`define TCN_OFF_FLAGS 12'h00C
`define TCN_OFF_ENAB 12'h010
`define TCN_OFF_OTHER 12'h014
`define TCN_OFF_PORTC 12'h018

`define TCN_CTRL_RESET 8'h00
`define TCN_B_WIDE 7
`define TCN_B_SELHI 6
`define TCN_B_DIVHI 5
`define TCN_B_DIVLO 4
`define TCN_B_SELLO 3
`define TCN_B_NOSYNC 2
`define TCN_B_EXTCLK 1
`define TCN_B_RUN 0
`define TCN_B_OVF 1
`define TCN_B_AUXOSC 3
`define TCN_SPECIAL_MODE 4'hB
`define TCN_INSTR_DIV 2'h3
`define TCN_CNT_WRAP 16'hFFFF

`endif

// [core/tcn_pkg.sv]
// tcn_pkg: types shared by the 16-bit timer/counter.
// assumes tcn_consts.svh on the include path.
package tcn_pkg;
  `include "tcn_consts.svh"

  typedef enum logic [2:0] {
    TCN_TIMER = 3'h1,
    TCN_SYNC_CNT = 3'h2,
    TCN_ASYNC_CNT = 3'h4
  } tcn_mode_e;

  typedef struct packed {
    logic [3:0] ccp1_mode;
    logic [3:0] ccp2_mode;
    logic ccp1_match;
    logic ccp2_match;
  } tcn_ccp_s;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic [7:0] hi_buf;
    logic [2:0] presc;
    logic ovf_flag;
    logic ovf_en;
    logic [7:0] other_ctrl;
    logic irq;
    logic [2:0] ext_sync;
    logic seen_fall;
    logic ext_prev;
    logic fosc_ph_carry;
    logic [1:0] fosc_ph;
    tcn_mode_e mode;
    logic [2:0] tb_sel;
    logic pins_input;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tcn_state_s;
endpackage : tcn_pkg

// [core/tcn_timer.sv]
// tcn_timer: 16-bit timer/counter with prescaler, wide access and apb port.
// assumes pclk is the oscillator clock; the instruction clock is pclk / 4.
// Overview of operation
// - wide-access bit set gives atomic 16-bit count access, else two bytes
// - select field 11/10/01/00 picks which units this timer serves
// - prescaler divides by 8, 4, 2, 1 for divide field 11, 10, 01, 00
// - external clock synchronised when sync-disable bit is zero
// - internal source ignores sync bit and counts instruction clock
// - external: rising edges after first falling edge; internal: osc/4
// - counts only while run bit is one
// - three modes: timer, synchronous counter, asynchronous counter
// - aux oscillator enabled forces its pins to inputs reading zero
// - wide mode: low-byte read copies live high byte into buffer
// - wide mode: high write loads buffer, low write commits both
// - wide mode: live high byte never directly accessible
// - low-byte write clears prescaler, high-byte write does not
// - count wraps ffff to 0000 and sets the overflow flag
// - overflow requests interrupt only while its enable bit is one
// - assigned unit special event trigger clears the counter
// - unit mode 1011 issues the trigger; may fail in async mode
// - software write to the count wins over a coincident trigger
`timescale 1ns/1ps
module tcn_timer
  import tcn_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_input,
  input wire tcn_ccp_s ccp_in,
  output logic overflow_irq,
  output logic [2:0] ccp_timebase,
  output logic osc_pins_input
);

  tcn_state_s s_q;
  tcn_state_s s_d;

  // true when the unit index (1..3) uses this timer as its time base
  function automatic logic serves(input logic [1:0] sel, input int unit);
    case (sel)
      2'b11: serves = 1'b1;
      2'b10: serves = (unit == 3);
      2'b01: serves = (unit >= 2);
      default: serves = 1'b0;
    endcase
  endfunction : serves

  function automatic logic [2:0] div_mask(input logic [1:0] sel);
    case (sel)
      2'b11: div_mask = 3'h7;
      2'b10: div_mask = 3'h3;
      2'b01: div_mask = 3'h1;
      default: div_mask = 3'h0;
    endcase
  endfunction : div_mask

  logic [1:0] sel_f;
  logic [2:0] serve_v;
  assign sel_f = {s_q.ctrl[`TCN_B_SELHI], s_q.ctrl[`TCN_B_SELLO]};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_tb
      assign serve_v[gi] = serves(sel_f, gi + 1);
    end
  endgenerate

  always_comb begin
    logic wr;
    logic rd;
    logic wide;
    logic ext_now;
    logic tick;
    logic inc;
    logic trig;
    logic wrap;
    logic [15:0] cnt;
    logic [2:0] pnext;
    wr = 1'b0;
    rd = 1'b0;
    wide = 1'b0;
    ext_now = 1'b0;
    tick = 1'b0;
    inc = 1'b0;
    trig = 1'b0;
    wrap = 1'b0;
    cnt = 16'h0000;
    pnext = 3'h0;
    s_d = s_q;
    // writes land on the edge that samples pready high; read data and the
    // buffer copy are taken a cycle earlier so both bytes share one instant
    wr = psel && penable && pwrite && s_q.pready;
    rd = psel && penable && !pwrite && !s_q.pready;
    wide = s_q.ctrl[`TCN_B_WIDE];
    s_d.pready = psel && penable && !s_q.pready;
    s_d.pslverr = 1'b0;
    if (psel && penable && pwrite && !s_q.pready
        && (paddr > `TCN_OFF_PORTC || paddr[1:0] != 2'h0))
      s_d.pslverr = 1'b1;
    s_d.ext_sync = {s_q.ext_sync[1:0], ext_count_input};
    s_d.fosc_ph = s_q.fosc_ph + 2'h1;
    s_d.fosc_ph_carry = (s_q.fosc_ph == `TCN_INSTR_DIV);
    // the raw pin is only seen through the synchroniser; the "async" path
    // trades the extra stage for one fewer cycle of edge latency
    ext_now = s_q.ctrl[`TCN_B_NOSYNC] ? s_q.ext_sync[1]
                                      : s_q.ext_sync[2];
    if (!s_q.ctrl[`TCN_B_EXTCLK]) begin
      s_d.mode = TCN_TIMER;
      tick = s_q.fosc_ph_carry;
    end else begin
      s_d.mode = s_q.ctrl[`TCN_B_NOSYNC] ? TCN_ASYNC_CNT
                                         : TCN_SYNC_CNT;
      tick = s_q.seen_fall && ext_now && !s_q.ext_prev;
    end
    s_d.ext_prev = ext_now;
    if (!ext_now) s_d.seen_fall = 1'b1;
    if (!s_q.ctrl[`TCN_B_EXTCLK]) s_d.seen_fall = 1'b0;
    cnt = {s_q.cnt_hi, s_q.cnt_lo};
    pnext = s_q.presc;
    if (s_q.ctrl[`TCN_B_RUN] && tick) begin
      if ((s_q.presc & div_mask({s_q.ctrl[`TCN_B_DIVHI],
                                 s_q.ctrl[`TCN_B_DIVLO]}))
          == div_mask({s_q.ctrl[`TCN_B_DIVHI], s_q.ctrl[`TCN_B_DIVLO]})) begin
        inc = 1'b1;
        pnext = 3'h0;
      end else begin
        pnext = s_q.presc + 3'h1;
      end
    end
    if (inc) begin
      wrap = (cnt == `TCN_CNT_WRAP);
      if (wrap) s_d.ovf_flag = 1'b1;
      cnt = cnt + 16'h0001;
    end
    trig = (serve_v[0] && ccp_in.ccp1_match
            && ccp_in.ccp1_mode == `TCN_SPECIAL_MODE)
        || (serve_v[1] && ccp_in.ccp2_match
            && ccp_in.ccp2_mode == `TCN_SPECIAL_MODE);
    if (trig) cnt = 16'h0000;
    s_d.presc = pnext;
    if (rd) begin
      case (paddr)
        `TCN_OFF_CTRL: s_d.prdata = {24'h0, s_q.ctrl};
        `TCN_OFF_CNTL: begin
          s_d.prdata = {24'h0, s_q.cnt_lo};
          if (wide) s_d.hi_buf = s_q.cnt_hi;
        end
        `TCN_OFF_CNTH: s_d.prdata = {24'h0, wide ? s_q.hi_buf
                                              : s_q.cnt_hi};
        `TCN_OFF_FLAGS: s_d.prdata = {30'h0, s_q.ovf_flag, 1'b0};
        `TCN_OFF_ENAB: s_d.prdata = {30'h0, s_q.ovf_en, 1'b0};
        `TCN_OFF_OTHER: s_d.prdata = {24'h0, s_q.other_ctrl};
        `TCN_OFF_PORTC: s_d.prdata = 32'h0000_0000;
        default: begin
          s_d.prdata = 32'h0000_0000;
          s_d.pslverr = 1'b1;
        end
      endcase
    end
    if (wr) begin
      case (paddr)
        `TCN_OFF_CTRL: s_d.ctrl = pwdata[7:0];
        `TCN_OFF_CNTL: begin
          cnt[7:0] = pwdata[7:0];
          if (wide) cnt[15:8] = s_q.hi_buf;
          s_d.presc = 3'h0;
        end
        `TCN_OFF_CNTH: begin
          if (wide) s_d.hi_buf = pwdata[7:0];
          else cnt[15:8] = pwdata[7:0];
        end
        `TCN_OFF_FLAGS: begin
          // an overflow in the clearing cycle keeps the flag set
          s_d.ovf_flag = pwdata[`TCN_B_OVF] | wrap;
        end
        `TCN_OFF_ENAB: s_d.ovf_en = pwdata[`TCN_B_OVF];
        `TCN_OFF_OTHER: s_d.other_ctrl = pwdata[7:0];
        `TCN_OFF_PORTC: ;
        default: ;
      endcase
    end
    s_d.cnt_lo = cnt[7:0];
    s_d.cnt_hi = cnt[15:8];
    s_d.irq = s_d.ovf_flag && s_d.ovf_en;
    s_d.tb_sel = serve_v;
    s_d.pins_input = s_d.other_ctrl[`TCN_B_AUXOSC];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.mode <= TCN_TIMER;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign overflow_irq = s_q.irq;
  assign ccp_timebase = s_q.tb_sel;
  assign osc_pins_input = s_q.pins_input;
endmodule : tcn_timer

// [tb/tb_top.sv]
// tb_top: self-checking bench for the 16-bit timer over apb.
// assumes tcn_ext_clk on the count pin and a 200 MHz pclk.
`timescale 1ns/1ps
`include "tcn_consts.svh"
module tb_top;
  import tcn_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, xen = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r, x;
  logic pready, pslverr, e, overflow_irq, osc_pins_input, ext_count_input;
  logic [2:0] ccp_timebase;
  tcn_ccp_s ccp_in = '0;
  int fails = 0, n_checks = 0, cyc = 0;
  logic [7:0] rows [4][2] = '{'{8'h48, 8'h07}, '{8'h40, 8'h04},
    '{8'h08, 8'h06}, '{8'h00, 8'h00}};
  always #2.5 pclk = ~pclk;
  tcn_timer dut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ext_count_input, .ccp_in, .overflow_irq,
    .ccp_timebase, .osc_pins_input);
  tcn_ext_clk #(.HALF_NS(37)) xclk(.en(xen), .clk_o(ext_count_input));
  task automatic chk(input logic [31:0] g, lo, hi);
    n_checks++;
    if ((g >= lo && g <= hi) !== 1'h1) begin
      fails++;
      $display("BAD %0t got %h want %h..%h", $time, g, lo, hi);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] lo, hi);
    apb(1'h0, a, 32'h0);
    chk(r, lo, hi);
  endtask : rd
  task automatic print_verdict;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict;
    end
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    rd(`TCN_OFF_CTRL, 32'h0, 32'h0);
    chk({overflow_irq, ccp_timebase, osc_pins_input}, 32'h0, 32'h0);
    foreach (rows[i]) begin
      wr(`TCN_OFF_CTRL, rows[i][0]);
      rd(`TCN_OFF_CTRL, rows[i][0], rows[i][0]);
      chk(ccp_timebase, rows[i][1], rows[i][1]);
    end
    // sync bit set on the internal source must make no difference
    for (int p = 0; p < 4; p++) begin
      wr(`TCN_OFF_CNTL, 32'h0);
      wr(`TCN_OFF_CTRL, 32'h5 | p << 4);
      repeat (256) @(posedge pclk);
      wr(`TCN_OFF_CTRL, 32'h4 | p << 4);
      rd(`TCN_OFF_CNTL, (64 >> p) - 1, (65 >> p) + 1);
    end
    wr(`TCN_OFF_CTRL, 32'h80);
    wr(`TCN_OFF_CNTH, 32'h12);
    wr(`TCN_OFF_CNTL, 32'h34);
    wr(`TCN_OFF_CNTH, 32'h56);
    rd(`TCN_OFF_CNTL, 32'h34, 32'h34);
    rd(`TCN_OFF_CNTH, 32'h12, 32'h12);
    wr(`TCN_OFF_ENAB, 32'h2);
    wr(`TCN_OFF_CNTH, 32'hFF);
    wr(`TCN_OFF_CNTL, 32'hF0);
    rd(`TCN_OFF_FLAGS, 32'h0, 32'h0);
    wr(`TCN_OFF_CTRL, 32'h81);
    repeat (100) @(posedge pclk);
    rd(`TCN_OFF_FLAGS, 32'h2, 32'h2);
    chk(overflow_irq, 32'h1, 32'h1);
    apb(1'h0, `TCN_OFF_CNTL, 32'h0);
    rd(`TCN_OFF_CNTH, 32'h0, 32'h0);
    wr(`TCN_OFF_ENAB, 32'h0);
    rd(`TCN_OFF_FLAGS, 32'h2, 32'h2);
    chk(overflow_irq, 32'h0, 32'h0);
    // trigger from an unassigned unit or another mode must not clear
    for (int m = 0; m < 3; m++) begin
      wr(`TCN_OFF_CTRL, m == 2 ? 32'h0 : 32'h48);
      ccp_in.ccp1_mode <= m == 0 ? 4'hA : 4'hB;
      wr(`TCN_OFF_CNTL, 32'h34);
      @(posedge pclk) ccp_in.ccp1_match <= 1'h1;
      @(posedge pclk) ccp_in.ccp1_match <= 1'h0;
      x = m == 1 ? 32'h0 : 32'h34;
      rd(`TCN_OFF_CNTL, x, x);
    end
    // trigger on the very edge that completes a count write: write wins
    wr(`TCN_OFF_CTRL, 32'h48);
    fork
      wr(`TCN_OFF_CNTL, 32'h56);
      begin
        repeat (3) @(posedge pclk);
        ccp_in.ccp1_match <= 1'h1;
        @(posedge pclk) ccp_in.ccp1_match <= 1'h0;
      end
    join
    rd(`TCN_OFF_CNTL, 32'h56, 32'h56);
    wr(`TCN_OFF_OTHER, 32'h8);
    rd(`TCN_OFF_PORTC, 32'h0, 32'h0);
    chk(osc_pins_input, 32'h1, 32'h1);
    for (int s = 0; s < 2; s++) begin
      wr(`TCN_OFF_CNTL, 32'h0);
      xen <= 1'h1;
      wr(`TCN_OFF_CTRL, 32'h3 | s << 2);
      repeat (400) @(posedge pclk);
      wr(`TCN_OFF_CTRL, 32'h2);
      xen <= 1'h0;
      rd(`TCN_OFF_CNTL, 32'h14, 32'h1C);
    end
    apb(1'h0, 12'h01C, 32'h0);
    chk(e, 32'h1, 32'h1);
    chk(r, 32'h0, 32'h0);
    print_verdict;
  end
endmodule : tb_top
bind tcn_timer tcn_timer_properties props(.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .overflow_irq,
  .ccp_timebase, .osc_pins_input);

// [tb/tcn_ext_clk.sv]
// tcn_ext_clk: external count clock driving the timer's count pin.
// assumes the bench gates it with en; it idles high while disabled.
`timescale 1ns/1ps
module tcn_ext_clk #(
  parameter int HALF_NS = 37
) (
  input wire logic en,
  output logic clk_o
);
  // idle high, so a falling edge always precedes the first counted rise
  initial clk_o = 1'h1;
  // aux source only with enable set, never the system clock
  always begin
    #(HALF_NS);
    clk_o = en ? ~clk_o : 1'h1;
  end
endmodule : tcn_ext_clk

// [tb/tcn_timer_properties.sv]
// tcn_timer_properties: bus and output checks on the timer's ports.
// assumes it is bound to tcn_timer and sees only its ports.
`timescale 1ns/1ps
`include "tcn_consts.svh"
module tcn_timer_properties
  import tcn_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic overflow_irq,
  input wire logic [2:0] ccp_timebase,
  input wire logic osc_pins_input
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pready;
  wire wr = acc && pwrite;
  wire ok = paddr <= `TCN_OFF_PORTC && paddr[1:0] == 2'h0;
  // write data two edges back, where registered outputs have settled
  logic [7:0] d1_q, d2_q;
  always_ff @(posedge pclk) begin
    d1_q <= pwdata[7:0];
    d2_q <= d1_q;
  end
  a_wait_one: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_no_stray: assert property (!(psel && penable) |=> !pready)
    else $error("pready without access");
  a_unmapped_err: assert property (acc && !ok |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && ok |-> !pslverr)
    else $error("mapped access refused");
  a_timebase_map: assert property (wr && paddr == `TCN_OFF_CTRL |-> ##2
    ccp_timebase == {d2_q[6] | d2_q[3], d2_q[3], d2_q[6] & d2_q[3]})
    else $error("timebase select wrong");
  a_pins_forced: assert property (wr && paddr == `TCN_OFF_OTHER |->
    ##2 osc_pins_input == d2_q[3])
    else $error("oscillator pins not forced");
  a_port_zero: assert property (acc && paddr == `TCN_OFF_PORTC |->
    prdata == 32'h0)
    else $error("forced pins read nonzero");
  a_irq_masked: assert property (wr && paddr == `TCN_OFF_ENAB
    && !pwdata[1] |-> ##2 !overflow_irq)
    else $error("masked overflow still requests");
  c_ctrl_wr: cover property (wr && paddr == `TCN_OFF_CTRL);
  c_irq: cover property ($rose(overflow_irq));
  c_err: cover property (pslverr);
endmodule : tcn_timer_properties
